// ===== adc_control_registers.sv
// Summary of operation
// - Interrupt request equals done flag and enable
// - Pin config: set bit makes analog input
// - Quiet mode halts CPU during conversion
// - Control: quiet, enable, flag, start, channel fields
// - Writing start bit launches one conversion
// - Start bit clears when conversion completes
// - X1: divide core clock by 4*prescale
// - X2: divide core clock by 2*prescale
// - High byte holds result bits 9..2
// - Low byte holds result bits 1..0
// - Reserved bits: software writes zero only
// - Reset clears control, standby, channel zero
// - Flag sets when result registers hold value
// - Channel select N picks input N
// - Start on non-analog pin does nothing
// - Conversion takes eleven converter clocks
module adc_control_registers (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // Special-function register port
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  // CPU and interrupt side
  input wire logic DOUBLE_SPEED,
  input wire logic CONV_IRQ_ENABLE,
  output logic CONV_IRQ,
  output logic CPU_HALT,
  // Analog core and input multiplexer
  output logic [7:0] PIN_ANALOG_SELECT,
  output logic CONVERTER_ENABLE,
  output logic [2:0] ANALOG_CHANNEL,
  output logic SAMPLE_HOLD,
  output logic CONV_CLK_TICK,
  output logic CONV_BUSY,
  input wire logic [9:0] ANALOG_RESULT
);
  import adc_ctrl_pkg::*;

  conv_tick_if tk ();

  conv_clock_divider u_div (
    .clk(CORE_CLK),
    .reset(RESET),
    .tk(tk)
  );

  // -----------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------
  logic [7:0] pin_config_q, pin_config_d;
  logic [4:0] prescale_q, prescale_d;
  logic quiet_q, quiet_d;
  logic enable_q, enable_d;
  logic done_q, done_d;
  logic start_q, start_d;
  logic [2:0] channel_q, channel_d;
  logic [9:0] result_q, result_d;
  logic [7:0] rdata_q, rdata_d;

  // -----------------------------------------------------------------
  // Sequencer state
  // -----------------------------------------------------------------
  conv_state_type state_q, state_d;
  logic [3:0] period_q, period_d;
  logic [2:0] conv_channel_q, conv_channel_d;

  logic wr_ctl;
  logic launch;
  logic finish;

  assign wr_ctl = SFR_WR && (SFR_ADDR == OFS_CONV_CONTROL);
  // Standby or a digital pin refuses the start; a running conversion is not restarted
  assign launch = wr_ctl && SFR_WDATA[CTL_START_STATUS_BIT] && (state_q == ST_IDLE)
                  && SFR_WDATA[CTL_CONVERTER_ENABLE_BIT]
                  && pin_config_q[SFR_WDATA[CTL_CHANNEL_MSB:CTL_CHANNEL_LSB]];
  assign finish = (state_q == ST_CONVERT) && tk.tick
                  && (period_q == 4'(CONV_PERIODS - 4'h1));

  // -----------------------------------------------------------------
  // Register file next values
  // -----------------------------------------------------------------
  always_comb begin
    pin_config_d = pin_config_q;
    prescale_d = prescale_q;
    quiet_d = quiet_q;
    enable_d = enable_q;
    done_d = done_q;
    start_d = start_q;
    channel_d = channel_q;
    result_d = result_q;
    if (SFR_WR && (SFR_ADDR == OFS_ANALOG_PIN_CONFIG)) begin
      pin_config_d = SFR_WDATA;
    end
    if (SFR_WR && (SFR_ADDR == OFS_CONV_CLOCK_PRESCALE)) begin
      prescale_d = SFR_WDATA[PRESCALE_MSB:0];
    end
    if (wr_ctl) begin
      quiet_d = SFR_WDATA[CTL_QUIET_CPU_HALT_BIT];
      enable_d = SFR_WDATA[CTL_CONVERTER_ENABLE_BIT];
      channel_d = SFR_WDATA[CTL_CHANNEL_MSB:CTL_CHANNEL_LSB];
      // Writing one to the flag keeps it; only a zero clears
      if (!SFR_WDATA[CTL_DONE_FLAG_BIT]) begin
        done_d = 1'b0;
      end
    end
    if (launch) begin
      start_d = 1'b1;
    end
    // Completion follows the clear so a same-cycle event is not lost
    if (finish) begin
      result_d = ANALOG_RESULT;
      done_d = 1'b1;
      start_d = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pin_config_q <= RST_PIN_CONFIG;
      prescale_q <= RST_PRESCALE;
      quiet_q <= 1'b0;
      enable_q <= 1'b0;
      done_q <= 1'b0;
      start_q <= 1'b0;
      channel_q <= RST_CHANNEL;
      result_q <= RST_RESULT;
    end else begin
      pin_config_q <= pin_config_d;
      prescale_q <= prescale_d;
      quiet_q <= quiet_d;
      enable_q <= enable_d;
      done_q <= done_d;
      start_q <= start_d;
      channel_q <= channel_d;
      result_q <= result_d;
    end
  end

  // -----------------------------------------------------------------
  // Conversion sequencer
  // -----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    period_d = period_q;
    conv_channel_d = conv_channel_q;
    unique case (state_q)
      ST_IDLE: begin
        period_d = 4'h0;
        if (launch) begin
          // Channel is frozen so a later write cannot move the multiplexer
          conv_channel_d = SFR_WDATA[CTL_CHANNEL_MSB:CTL_CHANNEL_LSB];
          state_d = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (tk.tick) begin
          period_d = 4'h1;
          state_d = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (finish) begin
          period_d = 4'h0;
          state_d = ST_IDLE;
        end else if (tk.tick) begin
          period_d = 4'(period_q + 4'h1);
        end
      end
      default: begin
        period_d = 4'h0;
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_q <= ST_IDLE;
      period_q <= 4'h0;
      conv_channel_q <= RST_CHANNEL;
    end else begin
      state_q <= state_d;
      period_q <= period_d;
      conv_channel_q <= conv_channel_d;
    end
  end

  assign tk.prescale = prescale_q;
  assign tk.double_speed = DOUBLE_SPEED;
  assign tk.run = (state_q != ST_IDLE);

  // -----------------------------------------------------------------
  // Register read port
  // -----------------------------------------------------------------
  // Reserved bits read as zero, which is one legal indeterminate value
  always_comb begin
    rdata_d = rdata_q;
    if (SFR_RD) begin
      unique case (SFR_ADDR)
        OFS_CONV_CLOCK_PRESCALE: rdata_d = {3'h0, prescale_q};
        OFS_CONV_CONTROL: rdata_d = {1'b0, quiet_q, enable_q, done_q,
                                     start_q, channel_q};
        OFS_CONV_RESULT_LOW: rdata_d = {6'h00, result_q[RESULT_LOW_MSB:0]};
        OFS_CONV_RESULT_HIGH: rdata_d = result_q[9:RESULT_LOW_MSB + 1];
        OFS_ANALOG_PIN_CONFIG: rdata_d = pin_config_q;
        default: rdata_d = RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      rdata_q <= RST_RDATA;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign SFR_RDATA = rdata_q;
  assign CONV_IRQ = done_q && CONV_IRQ_ENABLE;
  // Wake-up does not rely on the interrupt; the halt drops with the busy phase
  assign CPU_HALT = quiet_q && start_q;
  assign PIN_ANALOG_SELECT = pin_config_q;
  assign CONVERTER_ENABLE = enable_q;
  assign ANALOG_CHANNEL = conv_channel_q;
  assign SAMPLE_HOLD = (state_q == ST_SAMPLE);
  assign CONV_CLK_TICK = tk.tick;
  assign CONV_BUSY = start_q;
endmodule

// ===== adc_control_registers_assertions.sv
module adc_control_checker (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // Register port
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  // Converter side
  input wire logic DOUBLE_SPEED,
  input wire logic CONV_IRQ_ENABLE,
  input wire logic CONV_IRQ,
  input wire logic CPU_HALT,
  input wire logic [7:0] PIN_ANALOG_SELECT,
  input wire logic [2:0] ANALOG_CHANNEL,
  input wire logic SAMPLE_HOLD,
  input wire logic CONV_CLK_TICK,
  input wire logic CONV_BUSY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  logic [4:0] ps_q, ps_d;
  logic [6:0] gap_q, gap_d, period;
  logic [3:0] ticks_q, ticks_d;
  logic go;
  assign go = SFR_WR && SFR_ADDR == 8'hf3 && SFR_WDATA[3] && SFR_WDATA[5];
  always_comb begin
    ps_d = (SFR_WR && SFR_ADDR == 8'hf2) ? SFR_WDATA[4:0] : ps_q;
    gap_d = (CONV_CLK_TICK || !CONV_BUSY) ? 7'h01 : gap_q + 7'h01;
    ticks_d = !CONV_BUSY ? 4'h0 : ticks_q + {3'h0, CONV_CLK_TICK};
    period = (ps_q == 5'h00) ? 7'h40 : (DOUBLE_SPEED ? {1'b0, ps_q, 1'b0} : {ps_q, 2'b00});
  end
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ps_q <= 5'h00;
      gap_q <= 7'h01;
      ticks_q <= 4'h0;
    end else begin
      ps_q <= ps_d;
      gap_q <= gap_d;
      ticks_q <= ticks_d;
    end
  end
  a_irq_on_done:
    assert property ($fell(CONV_BUSY) |-> CONV_IRQ == CONV_IRQ_ENABLE) else $error("irq wrong at end");
  a_irq_gated:
    assert property (!CONV_IRQ_ENABLE |-> !CONV_IRQ) else $error("irq without enable");
  a_pin_cfg_load:
    assert property (SFR_WR && SFR_ADDR == 8'hf6 |=> PIN_ANALOG_SELECT == $past(SFR_WDATA))
      else $error("pin config not loaded");
  a_halt_only_busy:
    assert property (CPU_HALT |-> CONV_BUSY) else $error("halt while idle");
  a_launch_takes:
    assert property (go && PIN_ANALOG_SELECT[SFR_WDATA[2:0]] && !CONV_BUSY |=> CONV_BUSY
      && SAMPLE_HOLD && ANALOG_CHANNEL == $past(SFR_WDATA[2:0])) else $error("launch missed");
  a_digital_refused:
    assert property (go && !PIN_ANALOG_SELECT[SFR_WDATA[2:0]] && !CONV_BUSY |=> !CONV_BUSY)
      else $error("digital pin converted");
  a_eleven_ticks:
    assert property ($fell(CONV_BUSY) |-> ticks_q == 4'hb) else $error("tick count wrong");
  a_tick_period:
    assert property (CONV_CLK_TICK && CONV_BUSY |-> gap_q == period) else $error("tick spacing");
  a_sample_first:
    assert property ($fell(SAMPLE_HOLD) && CONV_BUSY |-> ticks_q == 4'h1)
      else $error("sample period wrong");
endmodule
bind adc_control_registers adc_control_checker u_adc_control_checker (.CORE_CLK(CORE_CLK),
  .RESET(RESET), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA),
  .DOUBLE_SPEED(DOUBLE_SPEED), .CONV_IRQ_ENABLE(CONV_IRQ_ENABLE), .CONV_IRQ(CONV_IRQ),
  .CPU_HALT(CPU_HALT), .PIN_ANALOG_SELECT(PIN_ANALOG_SELECT), .ANALOG_CHANNEL(ANALOG_CHANNEL),
  .SAMPLE_HOLD(SAMPLE_HOLD), .CONV_CLK_TICK(CONV_CLK_TICK), .CONV_BUSY(CONV_BUSY));

// ===== adc_control_registers_tb.sv
module adc_control_registers_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctrl_pkg::*;
  logic CORE_CLK = 1'b0, RESET = 1'b1, SFR_WR = 1'b0, SFR_RD = 1'b0;
  logic DOUBLE_SPEED = 1'b0, CONV_IRQ_ENABLE = 1'b0;
  logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, SFR_RDATA, PIN_ANALOG_SELECT;
  logic CONV_IRQ, CPU_HALT, CONVERTER_ENABLE, SAMPLE_HOLD, CONV_CLK_TICK, CONV_BUSY;
  logic [2:0] ANALOG_CHANNEL;
  logic [9:0] ANALOG_RESULT;
  int miscompares = 0, num_checks = 0, cycles = 0, n, pin, ps, per, ch, q, res;
  // Expected results in launch order, taken from the channel the rules select
  int exp_q[$];
  adc_control_registers u_adc_control_registers (.CORE_CLK(CORE_CLK), .RESET(RESET),
    .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA),
    .SFR_RDATA(SFR_RDATA), .DOUBLE_SPEED(DOUBLE_SPEED), .CONV_IRQ_ENABLE(CONV_IRQ_ENABLE),
    .CONV_IRQ(CONV_IRQ), .CPU_HALT(CPU_HALT), .PIN_ANALOG_SELECT(PIN_ANALOG_SELECT),
    .CONVERTER_ENABLE(CONVERTER_ENABLE), .ANALOG_CHANNEL(ANALOG_CHANNEL),
    .SAMPLE_HOLD(SAMPLE_HOLD), .CONV_CLK_TICK(CONV_CLK_TICK), .CONV_BUSY(CONV_BUSY),
    .ANALOG_RESULT(ANALOG_RESULT));
  analog_core_model u_analog_core_model (.clk(CORE_CLK), .enable(CONVERTER_ENABLE),
    .busy(CONV_BUSY), .channel(ANALOG_CHANNEL), .result(ANALOG_RESULT));
  initial begin
    forever #2 CORE_CLK = ~CORE_CLK;
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Worst case run is about 4900 cycles
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task check(string what, logic [15:0] seen, logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task bus(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge CORE_CLK);
    SFR_WR <= w;
    SFR_RD <= !w;
    SFR_ADDR <= a;
    SFR_WDATA <= d;
    @(posedge CORE_CLK);
    SFR_WR <= 1'b0;
    SFR_RD <= 1'b0;
    #1;
  endtask
  task rd(logic [7:0] a, int exp, string what);
    bus(1'b0, a, 8'h00);
    check(what, {8'h00, SFR_RDATA}, 16'(exp));
  endtask
  initial begin
    void'($urandom(32'he596));
    repeat (10) @(posedge CORE_CLK);
    RESET <= 1'b0;
    for (int a = 'hf1; a <= 'hf7; a++) rd(8'(a), 0, "reset read");
    check("reset busy", {15'h0, CONV_BUSY}, 16'h0);
    check("reset standby", {15'h0, CONVERTER_ENABLE}, 16'h0);
    $display("test reset done");
    pin = (($urandom % 256) | 'h0f) & 'h7f;
    bus(1'b1, 8'hf6, 8'(pin));
    rd(8'hf6, pin, "pin config");
    // Ones only on the read-only result bits; reserved bits are never set
    bus(1'b1, 8'hf4, 8'h03);
    rd(8'hf4, 0, "result low read only");
    bus(1'b1, 8'hf3, 8'h2f);
    check("digital start", {15'h0, CONV_BUSY}, 16'h0);
    bus(1'b1, 8'hf3, 8'h0b);
    check("standby start", {15'h0, CONV_BUSY}, 16'h0);
    check("standby", {15'h0, CONVERTER_ENABLE}, 16'h0);
    $display("test refusals done");
    // All pins analog so every channel code can be converted
    bus(1'b1, 8'hf6, 8'hff);
    // ----------------------------------------
    // Conversions over prescale, speed, quiet
    // ----------------------------------------
    for (int i = 0; i < 6; i++) begin
      ps = (i < 2) ? i : $urandom % 32;
      per = (ps == 0) ? 64 : (i % 2 == 1) ? 2 * ps : 4 * ps;
      ch = $urandom % 8;
      q = (i >= 4);
      @(posedge CORE_CLK);
      DOUBLE_SPEED <= i[0];
      CONV_IRQ_ENABLE <= i[1];
      bus(1'b1, 8'hf2, 8'(ps));
      bus(1'b1, 8'hf3, 8'('h28 | (q << 6) | ch));
      exp_q.push_back(ch * 37 + 100);
      check("quiet halt", {15'h0, CPU_HALT}, 16'(q));
      check("channel", {13'h0, ANALOG_CHANNEL}, 16'(ch));
      check("enable", {15'h0, CONVERTER_ENABLE}, 16'h1);
      n = 0;
      while (CONV_BUSY === 1'b1 && n < 2000) begin
        @(posedge CORE_CLK);
        #1;
        n++;
      end
      check("conv cycles", 16'(n), 16'(11 * per));
      res = exp_q.pop_front();
      check("irq", {15'h0, CONV_IRQ}, {15'h0, i[1]});
      rd(8'hf3, 'h30 | (q << 6) | ch, "control done");
      rd(8'hf5, res >> 2, "result high");
      rd(8'hf4, res & 3, "result low");
      bus(1'b1, 8'hf3, 8'('h20 | ch));
      check("irq cleared", {15'h0, CONV_IRQ}, 16'h0);
      $display("test conversion %0d done", i);
    end
    tally_and_finish();
  end
endmodule

// ===== adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ---------------------------------------------------------------
  // Register offsets in the special-function space
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CONV_CLOCK_PRESCALE = 8'hf2;
  localparam logic [7:0] OFS_CONV_CONTROL = 8'hf3;
  localparam logic [7:0] OFS_CONV_RESULT_LOW = 8'hf4;
  localparam logic [7:0] OFS_CONV_RESULT_HIGH = 8'hf5;
  localparam logic [7:0] OFS_ANALOG_PIN_CONFIG = 8'hf6;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int CTL_QUIET_CPU_HALT_BIT = 6;
  localparam int CTL_CONVERTER_ENABLE_BIT = 5;
  localparam int CTL_DONE_FLAG_BIT = 4;
  localparam int CTL_START_STATUS_BIT = 3;
  localparam int CTL_CHANNEL_MSB = 2;
  localparam int CTL_CHANNEL_LSB = 0;
  localparam int PRESCALE_MSB = 4;
  localparam int RESULT_LOW_MSB = 1;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PIN_CONFIG = 8'h00;
  localparam logic [4:0] RST_PRESCALE = 5'h00;
  localparam logic [2:0] RST_CHANNEL = 3'h0;
  localparam logic [9:0] RST_RESULT = 10'h000;
  localparam logic [7:0] RST_RDATA = 8'h00;

  // ---------------------------------------------------------------
  // Timing counts
  // ---------------------------------------------------------------
  localparam logic [3:0] CONV_PERIODS = 4'hb;
  localparam logic [6:0] DIV_PRESCALE_ZERO = 7'h40;
  localparam int DIV_SHIFT_X1 = 2;
  localparam int DIV_SHIFT_X2 = 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_type;

endpackage

// ===== analog_core_model.sv
module analog_core_model (
  // Clock
  input wire logic clk,
  // Converter controls
  input wire logic enable,
  input wire logic busy,
  input wire logic [2:0] channel,
  // Result to the block
  output logic [9:0] result
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] junk_q = 10'h2aa;
  // Idle result lines churn so a stale value is never mistaken for a result
  always_ff @(posedge clk) junk_q <= ~junk_q + 10'h001;
  assign result = (enable && busy) ? 10'(channel * 37 + 100) : junk_q;
endmodule

// ===== conv_clock_divider.sv
module conv_clock_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Tick link to the sequencer
  conv_tick_if.divider tk
);
  import adc_ctrl_pkg::*;

  logic [6:0] count_q;
  logic [6:0] count_d;
  logic [6:0] period;

  // -----------------------------------------------------------------
  // Converter clock period in core cycles
  // -----------------------------------------------------------------
  always_comb begin
    if (tk.prescale == RST_PRESCALE) begin
      period = DIV_PRESCALE_ZERO;
    end else if (tk.double_speed) begin
      period = 7'({tk.prescale} << DIV_SHIFT_X2);
    end else begin
      period = 7'({tk.prescale} << DIV_SHIFT_X1);
    end
  end

  // Compare with >= so a smaller prescale written mid-count cannot wrap
  assign tk.tick = tk.run && (count_q >= 7'(period - 7'h01));

  always_comb begin
    if (!tk.run || tk.tick) begin
      count_d = 7'h00;
    end else begin
      count_d = 7'(count_q + 7'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count_q <= 7'h00;
    end else begin
      count_q <= count_d;
    end
  end
endmodule

// ===== conv_tick_if.sv
interface conv_tick_if;
  logic [4:0] prescale;
  logic double_speed;
  logic run;
  logic tick;

  modport divider (
    input prescale,
    input double_speed,
    input run,
    output tick
  );

  modport sequencer (
    output prescale,
    output double_speed,
    output run,
    input tick
  );
endinterface
